// file: logic/rp_decoupler_defines.svh
`ifndef RP_DECOUPLER_DEFINES_SVH
`define RP_DECOUPLER_DEFINES_SVH
`define END_OF_STREAM_WORD 32'h0000000D
`define SAFE_DATA_VALUE    32'h00000000
`define MODULE_RESET_CYCLES 4
`define IMAGE_ADDR_RESET   16'h0000
`endif

// file: logic/rp_decoupler_pkg.sv
`default_nettype none
package rp_decoupler_pkg;
	typedef enum logic [5:0] {
		ST_IDLE     = 6'b000001,
		ST_FETCH    = 6'b000010,
		ST_FEED     = 6'b000100,
		ST_WAITDONE = 6'b001000,
		ST_MRESET   = 6'b010000,
		ST_RELEASE  = 6'b100000
	} seq_state_e;
	typedef logic [31:0] word_t;
endpackage
`default_nettype wire

// file: logic/stream_gate_if.sv
`timescale 1ns/10ps
`default_nettype none
interface stream_gate_if #(parameter int W = 32);
	logic         decouple;
	logic [W-1:0] rm_data;
	logic         rm_valid;
	logic         rm_ready;
	logic [W-1:0] st_data;
	logic         st_valid;
	logic         st_ready;
	modport gate (input decouple, rm_data, rm_valid, st_ready,
		output st_data, st_valid, rm_ready);
	modport ctrl (output decouple, rm_data, rm_valid, st_ready,
		input st_data, st_valid, rm_ready);
endinterface
`default_nettype wire

// file: logic/stream_gate.sv
`timescale 1ns/10ps
`default_nettype none
`include "rp_decoupler_defines.svh"
module stream_gate #(
	parameter int W = 32
) (
	input  wire logic    mclk_i, // Clock
	input  wire logic    rst_i,  // Async reset, high
	stream_gate_if.gate  g       // Gated stream
);
	logic [W-1:0] data_q;
	logic         valid_q;
	wire          take = g.rm_valid & g.rm_ready;
	// Handshakes forced inactive both ways while decoupled
	assign g.rm_ready = ~g.decouple & (~valid_q | g.st_ready);
	assign g.st_valid = valid_q & ~g.decouple;
	// Safe value substituted whenever decoupled
	assign g.st_data  = g.decouple ? W'(`SAFE_DATA_VALUE) : data_q;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			data_q  <= '0;
			valid_q <= 1'b0;
		end else if (g.decouple) begin
			valid_q <= 1'b0;
		end else begin
			if (take)
				data_q <= g.rm_data;
			if (take)
				valid_q <= 1'b1;
			else if (g.st_ready)
				valid_q <= 1'b0;
		end
	end
	property p_no_out_decoupled;
		@(posedge mclk_i) disable iff (rst_i)
		g.decouple |-> !g.st_valid && !g.rm_ready;
	endproperty
	a_no_out_decoupled: assert property (p_no_out_decoupled)
		else $error("handshake active while decoupled");
	property p_safe;
		@(posedge mclk_i) disable iff (rst_i)
		g.decouple |-> g.st_data == W'(`SAFE_DATA_VALUE);
	endproperty
	a_safe: assert property (p_safe)
		else $error("unsafe data while decoupled");
	property p_capture;
		@(posedge mclk_i) disable iff (rst_i)
		(take && !g.decouple) ##1 !g.decouple |-> g.st_data == $past(g.rm_data);
	endproperty
	a_capture: assert property (p_capture)
		else $error("captured data mismatch");
endmodule
`default_nettype wire

// file: logic/rp_decoupler.sv
// Operation
// - Ignore module outputs during reconfiguration
// - Outputs invalid until loaded and reset
// - Register outputs gated by decouple enable
// - Selector passes safe value when decoupled
// - Force boundary handshakes inactive when decoupled
// - Boundary bus still needs explicit decoupler
// - Disable bus interface during reconfiguration
// - Sequencer runs uninterrupted through reconfiguration
// - Config port unused when pins persist
// - Detect end word before releasing partition when auto_reset_i is low
// - Complete flag drops at start, rises done
`timescale 1ns/10ps
`default_nettype none
`include "rp_decoupler_defines.svh"
module rp_decoupler #(
	parameter int W  = 32,
	parameter int AW = 16,
	parameter int RST_CYCLES = `MODULE_RESET_CYCLES
) (
	input  wire logic          mclk_i,        // Clock 100 MHz
	input  wire logic          rst_i,         // Async reset, high
	input  wire logic          start_i,       // Begin partial load
	input  wire logic [AW-1:0] image_len_i,   // Image length in words
	input  wire logic          auto_reset_i,  // Wait on device done
	input  wire logic          pins_persist_i,// External pins own config
	input  wire logic          cfg_done_i,    // Config engine done pin
	output logic [AW-1:0]      mem_addr_o,    // Image memory address
	output logic               mem_rd_o,      // Image memory read
	input  wire logic [W-1:0]  mem_data_i,    // Word, one cycle after read
	output logic [W-1:0]       cfg_data_o,    // Config port word
	output logic               cfg_en_o,      // Config port write strobe
	output logic               rm_reset_o,    // Module reset
	output logic               decouple_o,    // Isolation active
	output logic               complete_o,    // Reconfig complete
	output logic               busy_o,        // Sequence running
	output logic               error_o,       // Start refused
	input  wire logic [W-1:0]  rm_data_i,     // Module stream data
	input  wire logic          rm_valid_i,    // Module stream valid
	output logic               rm_ready_o,    // Module stream ready
	output logic [W-1:0]       st_data_o,     // Static stream data
	output logic               st_valid_o,    // Static stream valid
	input  wire logic          st_ready_i     // Static stream ready
);
	////////////////////////////////////////////////////////////////////////
	rp_decoupler_pkg::seq_state_e state_q, state_d;
	logic [AW-1:0] addr_q;
	logic [7:0]    rcnt_q;
	logic          done_s1_q, done_s2_q;
	logic          rd_q, eos_q, err_q;
	logic [W-1:0]  word_q;
	stream_gate_if #(.W(W)) gif ();

	wire last_rd  = (addr_q == image_len_i - AW'(1));
	wire eos_seen = rd_q && (mem_data_i == `END_OF_STREAM_WORD);
	wire rst_done = (rcnt_q == 8'(RST_CYCLES - 1));

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
		end else begin
			done_s1_q <= cfg_done_i;
			done_s2_q <= done_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer shares no reset with the partition, so module reset never stalls it
	always_comb begin
		state_d = state_q;
		case (state_q)
			rp_decoupler_pkg::ST_IDLE:
				if (start_i && !pins_persist_i && image_len_i != '0)
					state_d = rp_decoupler_pkg::ST_FETCH;
			rp_decoupler_pkg::ST_FETCH:
				if (last_rd)
					state_d = rp_decoupler_pkg::ST_FEED;
			rp_decoupler_pkg::ST_FEED:
				state_d = rp_decoupler_pkg::ST_WAITDONE;
			rp_decoupler_pkg::ST_WAITDONE:
				if (auto_reset_i ? done_s2_q : eos_q)
					state_d = rp_decoupler_pkg::ST_MRESET;
			rp_decoupler_pkg::ST_MRESET:
				if (rst_done)
					state_d = rp_decoupler_pkg::ST_RELEASE;
			rp_decoupler_pkg::ST_RELEASE:
				state_d = rp_decoupler_pkg::ST_IDLE;
			default:
				state_d = rp_decoupler_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= rp_decoupler_pkg::ST_IDLE;
			addr_q  <= AW'(`IMAGE_ADDR_RESET);
			rcnt_q  <= 8'h00;
			rd_q    <= 1'b0;
			eos_q   <= 1'b0;
			err_q   <= 1'b0;
			word_q  <= '0;
		end else begin
			state_q <= state_d;
			rd_q    <= (state_q == rp_decoupler_pkg::ST_FETCH);
			word_q  <= mem_data_i;
			err_q   <= start_i && pins_persist_i && state_q == rp_decoupler_pkg::ST_IDLE;
			if (state_q == rp_decoupler_pkg::ST_IDLE)
				addr_q <= AW'(`IMAGE_ADDR_RESET);
			else if (state_q == rp_decoupler_pkg::ST_FETCH)
				addr_q <= addr_q + AW'(1);
			if (state_q == rp_decoupler_pkg::ST_IDLE)
				eos_q <= 1'b0;
			else if (eos_seen)
				eos_q <= 1'b1;
			if (state_q == rp_decoupler_pkg::ST_MRESET)
				rcnt_q <= rcnt_q + 8'h01;
			else
				rcnt_q <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	wire in_load = (state_q != rp_decoupler_pkg::ST_IDLE);
	logic cfg_en_q;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			cfg_en_q <= 1'b0;
		else
			cfg_en_q <= rd_q;
	end
	assign mem_addr_o = addr_q;
	assign mem_rd_o   = (state_q == rp_decoupler_pkg::ST_FETCH);
	assign cfg_data_o = word_q;
	assign cfg_en_o   = cfg_en_q;
	assign rm_reset_o = (state_q == rp_decoupler_pkg::ST_MRESET);
	// Release only after reset; RELEASE counts as decoupled for one cycle
	assign decouple_o = in_load;
	assign complete_o = ~in_load;
	assign busy_o     = in_load;
	assign error_o    = err_q;

	assign gif.decouple = in_load;
	assign gif.rm_data  = rm_data_i;
	assign gif.rm_valid = rm_valid_i;
	assign gif.st_ready = st_ready_i;
	assign rm_ready_o   = gif.rm_ready;
	assign st_data_o    = gif.st_data;
	assign st_valid_o   = gif.st_valid;

	stream_gate #(.W(W)) u_gate (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.g      (gif.gate)
	);

	////////////////////////////////////////////////////////////////////////
	property p_reset_decoupled;
		@(posedge mclk_i) disable iff (rst_i) rm_reset_o |-> decouple_o;
	endproperty
	a_reset_decoupled: assert property (p_reset_decoupled)
		else $error("module reset while coupled");
	property p_reset_len;
		@(posedge mclk_i) disable iff (rst_i)
		$rose(rm_reset_o) |-> rm_reset_o [*4] ##1 !rm_reset_o;
	endproperty
	a_reset_len: assert property (p_reset_len)
		else $error("module reset width wrong");
	property p_release_after_reset;
		@(posedge mclk_i) disable iff (rst_i)
		$fell(decouple_o) |-> $past(rm_reset_o, 2);
	endproperty
	a_release_after_reset: assert property (p_release_after_reset)
		else $error("released without module reset");
	property p_eos_before_release;
		@(posedge mclk_i) disable iff (rst_i)
		$rose(rm_reset_o) && !auto_reset_i |-> eos_q;
	endproperty
	a_eos_before_release: assert property (p_eos_before_release)
		else $error("release before end word");
	property p_complete;
		@(posedge mclk_i) disable iff (rst_i)
		($fell(complete_o) |-> $past(start_i)) and
		($rose(complete_o) |-> $past(rm_reset_o, 2));
	endproperty
	a_complete: assert property (p_complete)
		else $error("complete flag inconsistent");
	property p_in_order;
		@(posedge mclk_i) disable iff (rst_i)
		mem_rd_o ##1 mem_rd_o |-> mem_addr_o == $past(mem_addr_o) + AW'(1);
	endproperty
	a_in_order: assert property (p_in_order)
		else $error("image words out of order");
	property p_pass_through;
		@(posedge mclk_i) disable iff (rst_i)
		mem_rd_o ##1 1'b1 |-> ##1 (cfg_en_o && cfg_data_o == $past(mem_data_i));
	endproperty
	a_pass_through: assert property (p_pass_through)
		else $error("image word altered");
	property p_persist;
		@(posedge mclk_i) disable iff (rst_i)
		!busy_o && pins_persist_i |=> !busy_o;
	endproperty
	a_persist: assert property (p_persist)
		else $error("load started with persisted pins");
	property p_quiet;
		@(posedge mclk_i) disable iff (rst_i) decouple_o |-> !st_valid_o && !rm_ready_o;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("boundary active while decoupled");
	c_load: cover property (@(posedge mclk_i) disable iff (rst_i) $fell(decouple_o));
	c_eos: cover property (@(posedge mclk_i) disable iff (rst_i) eos_seen);
	c_refuse: cover property (@(posedge mclk_i) disable iff (rst_i) error_o);
	c_flow: cover property (@(posedge mclk_i) disable iff (rst_i) st_valid_o && st_ready_i);
endmodule
`default_nettype wire

// file: verif/rm_image_model.sv
`timescale 1ns/10ps
`default_nettype none
module rm_image_model (
	input  wire logic        mclk_i,     // Clock
	input  wire logic [15:0] mem_addr_i, // Word address
	input  wire logic        mem_rd_i,   // Read strobe
	input  wire logic [15:0] len_i,      // Image length
	output logic      [31:0] mem_data_o  // Word, one cycle later
);
	wire logic last_w = (mem_addr_i == len_i - 16'h0001);
	initial mem_data_o = 32'h00000000;
	// Between reads the bus toggles so a stale word never passes as fresh
	always @(posedge mclk_i) begin
		if (mem_rd_i) begin
			mem_data_o <= last_w ? 32'h0000000D : {16'hC35A, mem_addr_i};
		end else begin
			mem_data_o <= ~mem_data_o;
		end
	end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        mclk_i = 0, rst_i = 1, start_i = 0, auto_reset_i = 0;
	logic        pins_persist_i = 0, cfg_done_i = 0, rm_valid_i = 0, st_ready_i = 1;
	logic [15:0] image_len_i = 16'h0001, mem_addr_o;
	logic [31:0] mem_data_i, rm_data_i = 32'h00000000, cfg_data_o, st_data_o;
	logic        mem_rd_o, cfg_en_o, rm_reset_o, decouple_o, complete_o;
	logic        busy_o, error_o, rm_ready_o, st_valid_o;
	int          fail_count = 0, compares = 0;
	rp_decoupler dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(start_i),
		.image_len_i(image_len_i), .auto_reset_i(auto_reset_i),
		.pins_persist_i(pins_persist_i), .cfg_done_i(cfg_done_i), .mem_addr_o(mem_addr_o),
		.mem_rd_o(mem_rd_o), .mem_data_i(mem_data_i), .cfg_data_o(cfg_data_o),
		.cfg_en_o(cfg_en_o), .rm_reset_o(rm_reset_o), .decouple_o(decouple_o),
		.complete_o(complete_o), .busy_o(busy_o), .error_o(error_o), .rm_data_i(rm_data_i),
		.rm_valid_i(rm_valid_i), .rm_ready_o(rm_ready_o), .st_data_o(st_data_o),
		.st_valid_o(st_valid_o), .st_ready_i(st_ready_i));
	rm_image_model mem_u (.mclk_i(mclk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
		.len_i(image_len_i), .mem_data_o(mem_data_i));
	initial forever #5 mclk_i = ~mclk_i;
	////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Full load; the module stream chatters until module reset to prove it is ignored
	task automatic load(input logic [15:0] len, input logic aut);
		logic [31:0] got_q[$];
		int          rc;
		int          n;
		int          rdn;
		logic        quiet;
		rc = 0;
		rdn = 0;
		quiet = 1'b0;
		@(posedge mclk_i);
		image_len_i <= len;
		auto_reset_i <= aut;
		cfg_done_i <= ~aut;
		start_i <= 1'b1;
		rm_valid_i <= 1'b1;
		rm_data_i <= 32'hBAD0BAD0;
		for (n = 0; n < 300; n++) begin
			@(posedge mclk_i);
			start_i <= 1'b0;
			if (quiet) rm_valid_i <= 1'b0;
			if (aut && n == 21) cfg_done_i <= 1'b1;
			#1;
			if (cfg_en_o === 1'b1) got_q.push_back(cfg_data_o);
			if (mem_rd_o === 1'b1) begin
				chk(mem_addr_o, rdn);
				rdn++;
			end
			if (rm_reset_o === 1'b1) begin
				rc++;
				quiet = 1'b1;
				chk(decouple_o, 1'b1);
			end
			if (decouple_o === 1'b1) begin
				chk(st_valid_o, 1'b0);
				chk(rm_ready_o, 1'b0);
				chk(st_data_o, 32'h00000000);
			end
			if (aut && n == 20) chk(decouple_o, 1'b1);
			if (n > 2 && busy_o === 1'b0) break;
		end
		if (n == 300) begin
			fail_count++;
			conclude();
		end else begin
			chk(rdn, len);
			chk(got_q.size(), len);
			foreach (got_q[k])
				chk(got_q[k], (k == len - 1) ? 32'h0000000D : {16'hC35A, k[15:0]});
			chk(rc, 4);
			chk(complete_o, 1'b1);
			chk(decouple_o, 1'b0);
			$display("load len=%0d auto=%0d done", len, aut);
		end
	endtask
	task automatic stream_pass();
		int n;
		@(posedge mclk_i);
		rm_data_i <= 32'h13579BDF;
		rm_valid_i <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk_i);
			#1;
			if (st_valid_o === 1'b1) break;
		end
		if (n == 20) begin
			fail_count++;
			conclude();
		end else begin
			chk(st_data_o, 32'h13579BDF);
			chk(rm_ready_o, 1'b1);
			@(posedge mclk_i);
			rm_valid_i <= 1'b0;
			$display("stream pass done");
		end
	endtask
	task automatic refuse();
		logic [31:0] seen;
		logic        b;
		seen = 0;
		b = 0;
		@(posedge mclk_i);
		pins_persist_i <= 1'b1;
		start_i <= 1'b1;
		repeat (3) begin
			@(posedge mclk_i);
			start_i <= 1'b0;
			#1;
			seen = seen + error_o;
			b = b | busy_o;
		end
		chk(seen, 1);
		chk(b, 1'b0);
		@(posedge mclk_i);
		pins_persist_i <= 1'b0;
		$display("refuse done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		load(16'h0003, 1'b0);
		load(16'h0006, 1'b1);
		stream_pass();
		refuse();
		load(16'h0001, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
